// >>> hdl/gcs_pin_unit.sv
// Pin drive-low and pin-level readback unit with APB register access
`timescale 1ns/10ps
`include "gcs_map.svh"
module gcs_pin_unit
  import gcs_pkg::*;
#(
  parameter int NUM_PINS = `GCS_NUM_PINS
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // APB
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [`GCS_ADDR_BITS-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Pins
  input  wire logic [NUM_PINS-1:0]       pinIn,
  output logic      [NUM_PINS-1:0]       pinOut,
  output logic      [NUM_PINS-1:0]       pinOeN
);
  localparam int FLAT_BITS = 4 * `GCS_WORD_BITS;

  gcs_reg_if regPath ();

  gcs_bank_vec_t         dir_ff;
  gcs_bank_vec_t         nxt_dir;
  gcs_bank_vec_t         out_ff;
  gcs_bank_vec_t         nxt_out;
  gcs_bank_vec_t         levelVec;
  logic [NUM_PINS-1:0]   syncLevel;
  logic [FLAT_BITS-1:0]  dirFlat;
  logic [FLAT_BITS-1:0]  outFlat;
  gcs_word_t             mask;
  gcs_word_t             outPins;

  // Only the bank 6 word is partly populated; upper bits never hold state
  function automatic gcs_word_t pair_mask(input gcs_pair_t pair);
    pair_mask = (pair == 2'h3) ? `GCS_BANK6_MASK : `GCS_FULL_MASK;
  endfunction

  gcs_apb_slave u_apb (
    .clk     (clk),
    .rst     (rst),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .regBus  (regPath.bus)
  );

  gcs_pin_sync #(
    .WIDTH (NUM_PINS)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .pinIn    (pinIn),
    .levelOut (syncLevel)
  );

  // Pin n sits at word n/32, bit n%32: even bank low half, odd bank high half
  assign levelVec = gcs_bank_vec_t'({{(FLAT_BITS-NUM_PINS){1'b0}}, syncLevel});
  assign mask     = pair_mask(regPath.pair);
  // Bits of the addressed word whose pins are outputs and exist
  assign outPins  = ~dir_ff[regPath.pair] & mask;

  always_comb begin
    nxt_dir = dir_ff;
    nxt_out = out_ff;
    if (regPath.wrEn) begin
      case (regPath.grp)
        GCS_GRP_DIR: begin
          nxt_dir[regPath.pair] = regPath.wdata | ~mask;
        end
        GCS_GRP_OUT: begin
          nxt_out[regPath.pair] = (out_ff[regPath.pair] & ~outPins)
                                  | (regPath.wdata & outPins);
        end
        GCS_GRP_CLR: begin
          nxt_out[regPath.pair] = out_ff[regPath.pair] & ~(regPath.wdata & outPins);
        end
        default: begin
          nxt_out = out_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_ff <= {4{`GCS_DIR_RESET}};
      out_ff <= {4{`GCS_OUT_RESET}};
    end else begin
      dir_ff <= nxt_dir;
      out_ff <= nxt_out;
    end
  end

  always_comb begin
    case (regPath.grp)
      GCS_GRP_DIR: begin
        regPath.rdata = dir_ff[regPath.pair] & mask;
      end
      GCS_GRP_CLR: begin
        regPath.rdata = out_ff[regPath.pair] & mask;
      end
      GCS_GRP_LEVEL: begin
        // Inputs show the synchronised pin, outputs the driven value
        regPath.rdata = ((levelVec[regPath.pair] & dir_ff[regPath.pair])
                        | (out_ff[regPath.pair] & ~dir_ff[regPath.pair])) & mask;
      end
      default: begin
        regPath.rdata = out_ff[regPath.pair] & mask;
      end
    endcase
  end

  assign dirFlat = dir_ff;
  assign outFlat = out_ff;
  assign pinOut  = outFlat[NUM_PINS-1:0];
  // Enable is low while the pin is driven, that is while its direction bit is 0
  assign pinOeN  = dirFlat[NUM_PINS-1:0];
endmodule

// >>> hdl/gcs_map.svh
// Register offsets, field positions and reset values of the pin drive-low and pin-level block
`ifndef GCS_MAP_SVH
`define GCS_MAP_SVH

`define GCS_NUM_PINS      104
`define GCS_WORD_BITS     32
`define GCS_ADDR_BITS     12

// Register groups, four words each
`define GCS_DIR_BASE      12'h000
`define GCS_OUT_BASE      12'h010
`define GCS_CLR_BASE      12'h020
`define GCS_LEVEL_BASE    12'h030
`define GCS_MAP_END       12'h040

// Word offsets inside a group
`define GCS_PAIR_01       12'h000
`define GCS_PAIR_23       12'h004
`define GCS_PAIR_45       12'h008
`define GCS_PAIR_6        12'h00c

// Field positions
`define GCS_ODD_BANK_MSB  31
`define GCS_ODD_BANK_LSB  16
`define GCS_EVEN_BANK_MSB 15
`define GCS_EVEN_BANK_LSB 0
`define GCS_BANK6_MASK    32'h000000ff
`define GCS_FULL_MASK     32'hffffffff

// Reset values
`define GCS_DIR_RESET     32'hffffffff
`define GCS_OUT_RESET     32'h00000000
`define GCS_RDATA_RESET   32'h00000000

`endif

// >>> hdl/gcs_pkg.sv
// Types shared by the pin drive-low and pin-level block
package gcs_pkg;

  typedef enum logic [1:0] {
    GCS_GRP_DIR   = 2'h0,
    GCS_GRP_OUT   = 2'h1,
    GCS_GRP_LEVEL = 2'h3,
    GCS_GRP_CLR   = 2'h2
  } gcs_group_t;

  typedef logic [1:0]  gcs_pair_t;
  typedef logic [31:0] gcs_word_t;
  typedef gcs_word_t [3:0] gcs_bank_vec_t;

endpackage

// >>> hdl/gcs_reg_if.sv
// Register access path between the bus slave and the pin register logic
`timescale 1ns/10ps
interface gcs_reg_if;
  import gcs_pkg::*;

  logic       wrEn;
  gcs_group_t grp;
  gcs_pair_t  pair;
  gcs_word_t  wdata;
  gcs_word_t  rdata;

  modport bus (
    output wrEn,
    output grp,
    output pair,
    output wdata,
    input  rdata
  );

  modport regs (
    input  wrEn,
    input  grp,
    input  pair,
    input  wdata,
    output rdata
  );
endinterface

// >>> hdl/gcs_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module gcs_pin_sync #(
  parameter int WIDTH = 104
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Pins and synchronised levels
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] levelOut
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;
  logic [WIDTH-1:0] level_ff;
  logic [WIDTH-1:0] nxt_level;

  // A bit moves only once stages two and three agree; stage one feeds stage two alone
  always_comb begin
    nxt_level = (level_ff & (stage2_ff ^ stage3_ff)) | (stage3_ff & ~(stage2_ff ^ stage3_ff));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
      stage3_ff <= '0;
      level_ff  <= '0;
    end else begin
      stage1_ff <= pinIn;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      level_ff  <= nxt_level;
    end
  end

  assign levelOut = level_ff;
endmodule

// >>> hdl/gcs_apb_slave.sv
// APB slave front end: decode, write strobe and registered read data
`timescale 1ns/10ps
`include "gcs_map.svh"
module gcs_apb_slave
  import gcs_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // APB
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [`GCS_ADDR_BITS-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Register path
  gcs_reg_if.bus                         regBus
);
  logic      mapped;
  logic      setup;
  logic      access;
  gcs_word_t rdata_ff;
  gcs_word_t nxt_rdata;

  always_comb begin
    mapped      = 1'b1;
    regBus.grp  = GCS_GRP_DIR;
    if (paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end else if (paddr >= `GCS_MAP_END) begin
      mapped = 1'b0;
    end else if (paddr >= `GCS_LEVEL_BASE) begin
      regBus.grp = GCS_GRP_LEVEL;
    end else if (paddr >= `GCS_CLR_BASE) begin
      regBus.grp = GCS_GRP_CLR;
    end else if (paddr >= `GCS_OUT_BASE) begin
      regBus.grp = GCS_GRP_OUT;
    end
  end

  assign regBus.pair  = paddr[3:2];
  assign regBus.wdata = pwdata;
  assign setup        = psel & ~penable;
  assign access       = psel & penable;
  assign regBus.wrEn  = access & pwrite & mapped;

  // Read data is taken in the setup cycle so prdata comes from a flop
  always_comb begin
    nxt_rdata = rdata_ff;
    if (setup) begin
      nxt_rdata = (mapped && !pwrite) ? regBus.rdata : `GCS_RDATA_RESET;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= `GCS_RDATA_RESET;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Zero wait states; an unmapped or misaligned address answers with an error
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata  = rdata_ff;
endmodule

// >>> verification/gcs_pin_unit_chk.sv
// Port-level assertions for the pin drive-low and pin-level unit
`timescale 1ns/10ps
module gcs_pin_unit_chk #(
  parameter int NUM_PINS = 104
) (
  // Clock, reset and APB
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // Pins
  input wire logic [NUM_PINS-1:0] pinIn,
  input wire logic [NUM_PINS-1:0] pinOut,
  input wire logic [NUM_PINS-1:0] pinOeN
);
  logic wrAcc;
  logic rdSet;
  assign wrAcc = psel && penable && pwrite;
  // Read data is captured at the setup edge
  assign rdSet = psel && !penable && !pwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  clr_even_a: assert property (wrAcc && paddr == 12'h024 && pwdata[0] && !pinOeN[32]
    |=> !pinOut[32]) else $error("even bank clear missed");
  clr_odd_a: assert property (wrAcc && paddr == 12'h024 && pwdata[16] && !pinOeN[48]
    |=> !pinOut[48]) else $error("odd bank clear missed");
  clr_input_a: assert property (wrAcc && paddr == 12'h024 && pinOeN[33]
    |=> $stable(pinOut[33])) else $error("input pin drive changed");
  clr_bank6_a: assert property (wrAcc && paddr == 12'h02c && pwdata[0] && !pinOeN[96]
    |=> !pinOut[96]) else $error("bank 6 clear missed");
  clr_read_a: assert property (rdSet && paddr == 12'h024
    |=> prdata == $past(pinOut[63:32])) else $error("drive state readback wrong");
  level_out_a: assert property (rdSet && paddr == 12'h034
    |=> ((prdata ^ $past(pinOut[63:32])) & ~$past(pinOeN[63:32])) == 32'h0)
    else $error("driven level readback wrong");
  bank6_rsv_a: assert property (rdSet && paddr == 12'h02c
    |=> prdata[31:8] == 24'h0) else $error("reserved bits not zero");
  // Pin 3 sits high in the outside pattern, so a level stuck at its reset value is caught
  level_in_a: assert property ((pinOeN[3] && $stable(pinIn[3]))[*7] ##0
    (rdSet && paddr == 12'h030) |=> prdata[3] == $past(pinIn[3]))
    else $error("input level readback wrong");
endmodule

bind gcs_pin_unit gcs_pin_unit_chk #(.NUM_PINS(NUM_PINS)) uChk (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut),
  .pinOeN(pinOeN));

// >>> verification/gcs_pin_world.sv
// Far side of the pins: driven pins loop back, others show an outside pattern
`timescale 1ns/10ps
module gcs_pin_world #(
  parameter int NUM_PINS = 104
) (
  // Device side
  input  wire logic [NUM_PINS-1:0] pinOut,
  input  wire logic [NUM_PINS-1:0] pinOeN,
  // Outside source and resolved wire
  input  wire logic [NUM_PINS-1:0] extVal,
  output logic      [NUM_PINS-1:0] pinIn
);
  // A pin the device drives carries its level, so the readback sees the wire
  assign pinIn = (pinOut & ~pinOeN) | (extVal & pinOeN);
endmodule

// >>> verification/test_gcs_pin_unit.sv
// Self-checking bench for the pin drive-low and pin-level unit
`timescale 1ns/10ps
module test_gcs_pin_unit;
  import gcs_pkg::*;
  typedef struct {
    logic        wr;
    logic [11:0] addr;
    gcs_word_t   data;
  } gcs_row_t;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [11:0]  paddr = 12'h000;
  gcs_word_t    pwdata = 32'h0;
  gcs_word_t    prdata;
  logic         pready;
  logic         pslverr;
  logic [103:0] pinIn;
  logic [103:0] pinOut;
  logic [103:0] pinOeN;
  logic [103:0] extVal = {8'h00, 32'h0, 32'h5a5a5a5a, 32'h12345678};
  int           fails = 0;
  int           checkCount = 0;
  int           cyc = 0;
  gcs_word_t    rd;
  logic         err;
  // Reads carry the expected word in data
  gcs_row_t rows [16] = '{'{0, 12'h030, 32'h12345678}, '{0, 12'h020, 32'h0},
    '{1, 12'h004, 32'hffff0000}, '{1, 12'h014, 32'hffffffff}, '{0, 12'h024, 32'h0000ffff},
    '{1, 12'h024, 32'h000000f1}, '{0, 12'h024, 32'h0000ff0e}, '{1, 12'h004, 32'h0000ffff},
    '{1, 12'h014, 32'hffffffff}, '{1, 12'h024, 32'h00ff00ff}, '{0, 12'h024, 32'hff00ff0e},
    '{0, 12'h034, 32'hff005a5a}, '{1, 12'h00c, 32'h0}, '{1, 12'h01c, 32'hffffffff},
    '{1, 12'h02c, 32'hffffff0f}, '{0, 12'h02c, 32'h000000f0}};

  gcs_pin_unit uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN));
  gcs_pin_world uWorld (.pinOut(pinOut), .pinOeN(pinOeN), .extVal(extVal), .pinIn(pinIn));

  always #12.5 clk = ~clk;

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input gcs_word_t seen, input gcs_word_t want);
    checkCount++;
    if (seen !== want) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // Idle edge first so a release is never reassigned in the same step
  task automatic apb(input logic w, input logic [11:0] a, input gcs_word_t d,
                     output gcs_word_t r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(pinOeN[31:0], 32'hffffffff);
    chk(pinOut[31:0], 32'h0);
    repeat (8) @(posedge clk);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].data, rd, err);
      if (!rows[i].wr) chk(rd, rows[i].data);
    end
    chk({24'h0, pinOut[103:96]}, 32'h000000f0);
    chk({16'h0, pinOut[63:48]}, 32'h0000ff00);
    // Misaligned write is refused and must leave the drive state alone
    apb(1'b1, 12'h026, 32'hffffffff, rd, err);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h024, 32'h0, rd, err);
    chk(rd, 32'hff00ff0e);
    chk({31'h0, err}, 32'h0);
    chk({31'h0, pready}, 32'h1);
    apb(1'b0, 12'h040, 32'h0, rd, err);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(pinOeN[103:72], 32'hffffffff);
    chk(pinOut[63:32], 32'h0);
    apb(1'b0, 12'h02c, 32'h0, rd, err);
    chk(rd, 32'h0);
    tally_and_finish();
  end
endmodule
